//--- hdl/ccc_classifier.sv
// CPU capture classifier: per-frame copy, redirect and queue decision.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// RULE1: OR all capture events into queue mask.
// RULE2: Redirect removes every front port.
// RULE3: Copy leaves front-port forwarding unchanged.
// RULE4: Reserved bridge range with configurable action.
// RULE5: GARP range with configurable action.
// RULE6: Fault-management range with configurable action.
// RULE7: IPv4 multicast MAC with IGMP redirects.
// RULE8: MLD router-alert hop-by-hop frames redirect.
// RULE9: Other hop-by-hop IPv6 frames redirect.
// RULE10: ICMPv6 frames redirect.
// RULE11: IPv4 local control multicast copies.
// RULE12: IPv6 link-local multicast control copies.
// RULE13: Own queue per type, hop-by-hop/ICMPv6 share.
// RULE14: Bridge-range queues from separate configuration.
// RULE15: Only untagged or enabled outer TPID considered, except register-access frames.
// RULE16: Register-access VLAN check follows aware setting.
// RULE17: Double-tagged frames fail register-access VLAN check.
// RULE18: Register access needs EtherType and protocol identifier.
// RULE19: Masked 32-bit header compare, mask is don't-care.
// RULE20: Passing enabled register-access frames redirect.
// RULE21: Per-address enable and action for bridge range.
// RULE22: Range bounds inclusive; mask one means ignore.
// RULE23: One decision per frame after parsing.
module ccc_classifier (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic frm_valid_in,
   input wire logic [47:0] frm_dmac_in,
   input wire logic [1:0] frm_tag_count_in,
   input wire logic [2:0] frm_outer_tpid_in,
   input wire logic [11:0] frm_outer_vid_in,
   input wire logic [15:0] frm_ethertype_in,
   input wire logic [15:0] frm_proto_id_in,
   input wire logic [31:0] frm_regacc_hdr_in,
   input wire logic frm_is_ipv4_in,
   input wire logic frm_is_ipv6_in,
   input wire logic [7:0] frm_ip_proto_in,
   input wire logic [31:0] frm_ipv4_dip_in,
   input wire logic [15:0] frm_ipv6_dip_top_in,
   input wire logic [7:0] frm_hbh_opt_type_in,
   input wire logic [7:0] frm_hbh_opt_len_in,
   input wire logic [15:0] frm_hbh_opt_data_in,
   input wire logic [7:0] frm_ext_queue_mask_in,
   input wire logic frm_ext_redirect_in,
   output logic res_valid_out,
   output logic [7:0] res_queue_mask_out,
   output logic res_redirect_out,
   output logic res_copy_out,
   output logic res_discard_out,
   output logic res_front_ports_keep_out
);
   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [31:0] capture_q;
   logic [15:0] bridge_en_q;
   logic [31:0] bridge_act_q;
   logic [3:0] group_act_q;
   logic [8:0] bridge_ctrl_queue_select_q;
   logic [26:0] protocol_queue_select_q;
   logic [12:0] regaccess_vlan_config_q;
   logic [31:0] regaccess_header_match_value_q;
   logic [31:0] regaccess_header_dont_care_q;
   logic [15:0] frame_count_q;
   logic [31:0] rdata_q;
   logic wait_q;
   // Single-cycle wait state so read data is registered before the accepting edge.
   // Writes commit only at the edge where waitrequest is low, as the master sees it.
   wire req_w = (avs_read_in | avs_write_in) & wait_q;
   wire wr_w = avs_write_in & ~wait_q;
   wire [31:0] be_w = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                       {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] be);
      merge = (old & ~be) | (nw & be);
   endfunction : merge
   wire [31:0] cap_m = merge(capture_q, avs_writedata_in, be_w);
   wire [31:0] ben_m = merge({16'h0000, bridge_en_q}, avs_writedata_in, be_w);
   wire [31:0] bact_m = merge(bridge_act_q, avs_writedata_in, be_w);
   wire [31:0] gact_m = merge({28'h0000000, group_act_q}, avs_writedata_in, be_w);
   wire [31:0] bq_m = merge({23'h000000, bridge_ctrl_queue_select_q}, avs_writedata_in, be_w);
   wire [31:0] pq_m = merge({5'h00, protocol_queue_select_q}, avs_writedata_in, be_w);
   wire [31:0] rv_m = merge({19'h00000, regaccess_vlan_config_q}, avs_writedata_in, be_w);
   wire [31:0] rd_m = merge(regaccess_header_match_value_q, avs_writedata_in, be_w);
   wire [31:0] rm_m = merge(regaccess_header_dont_care_q, avs_writedata_in, be_w);
   logic [31:0] rmux_w;
   always_comb begin
      if (avs_address_in == ccc_pkg::A_CAPTURE) begin
         rmux_w = capture_q;
      end else if (avs_address_in == ccc_pkg::A_BRIDGE_EN) begin
         rmux_w = {16'h0000, bridge_en_q};
      end else if (avs_address_in == ccc_pkg::A_BRIDGE_ACT) begin
         rmux_w = bridge_act_q;
      end else if (avs_address_in == ccc_pkg::A_GROUP_ACT) begin
         rmux_w = {28'h0000000, group_act_q};
      end else if (avs_address_in == ccc_pkg::A_BQUEUE) begin
         rmux_w = {23'h000000, bridge_ctrl_queue_select_q};
      end else if (avs_address_in == ccc_pkg::A_PQUEUE) begin
         rmux_w = {5'h00, protocol_queue_select_q};
      end else if (avs_address_in == ccc_pkg::A_RVLAN) begin
         rmux_w = {19'h00000, regaccess_vlan_config_q};
      end else if (avs_address_in == ccc_pkg::A_RDATA) begin
         rmux_w = regaccess_header_match_value_q;
      end else if (avs_address_in == ccc_pkg::A_RMASK) begin
         rmux_w = regaccess_header_dont_care_q;
      end else if (avs_address_in == ccc_pkg::A_STATUS) begin
         rmux_w = {16'h0000, frame_count_q};
      end else begin
         rmux_w = ccc_pkg::UNMAPPED_DATA;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         wait_q <= 1'b1;
         rdata_q <= ccc_pkg::RESET_ZERO;
      end else begin
         wait_q <= ~req_w;
         if (req_w & avs_read_in) begin
            rdata_q <= rmux_w;
         end
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         capture_q <= ccc_pkg::RESET_ZERO;
         bridge_en_q <= 16'h0000;
         bridge_act_q <= ccc_pkg::RESET_ZERO;
         group_act_q <= 4'h0;
         bridge_ctrl_queue_select_q <= 9'h000;
         protocol_queue_select_q <= 27'h0000000;
         regaccess_vlan_config_q <= 13'h0000;
         regaccess_header_match_value_q <= ccc_pkg::RESET_ZERO;
         regaccess_header_dont_care_q <= ccc_pkg::RESET_ZERO;
      end else if (wr_w) begin
         if (avs_address_in == ccc_pkg::A_CAPTURE) capture_q <= cap_m;
         if (avs_address_in == ccc_pkg::A_BRIDGE_EN) bridge_en_q <= ben_m[15:0];
         if (avs_address_in == ccc_pkg::A_BRIDGE_ACT) bridge_act_q <= bact_m;
         if (avs_address_in == ccc_pkg::A_GROUP_ACT) group_act_q <= gact_m[3:0];
         if (avs_address_in == ccc_pkg::A_BQUEUE) bridge_ctrl_queue_select_q <= bq_m[8:0];
         if (avs_address_in == ccc_pkg::A_PQUEUE) protocol_queue_select_q <= pq_m[26:0];
         if (avs_address_in == ccc_pkg::A_RVLAN) regaccess_vlan_config_q <= rv_m[12:0];
         if (avs_address_in == ccc_pkg::A_RDATA) regaccess_header_match_value_q <= rd_m;
         if (avs_address_in == ccc_pkg::A_RMASK) regaccess_header_dont_care_q <= rm_m;
      end
   end
   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = wait_q;
   // ***************************************************************
   // Frame classification
   // ***************************************************************
   // Range compares are inclusive at both ends.
   wire in_bridge = (frm_dmac_in >= ccc_pkg::BRIDGE_LO) && (frm_dmac_in <= ccc_pkg::BRIDGE_HI); // RULE22
   wire in_garp = (frm_dmac_in >= ccc_pkg::GARP_LO) && (frm_dmac_in <= ccc_pkg::GARP_HI);
   wire in_cfm = (frm_dmac_in >= ccc_pkg::CFM_LO) && (frm_dmac_in <= ccc_pkg::CFM_HI);
   wire in_v4mc = (frm_dmac_in >= ccc_pkg::V4MC_LO) && (frm_dmac_in <= ccc_pkg::V4MC_HI);
   wire in_v6mc = (frm_dmac_in >= ccc_pkg::V6MC_LO) && (frm_dmac_in <= ccc_pkg::V6MC_HI);
   wire [4:0] tpid_dis_w = capture_q[ccc_pkg::F_TPID_LO +: ccc_pkg::NUM_TPID];
   // Untagged frames, or outer TPID not disabled, are eligible.
   wire tpid_ok = (frm_tag_count_in == 2'h0) || !tpid_dis_w[frm_outer_tpid_in]; // RULE15
   wire [3:0] bidx = frm_dmac_in[3:0];
   wire bridge_en = bridge_en_q[bidx]; // RULE21
   wire [1:0] bridge_act = bridge_act_q[{bidx, 1'b0} +: 2]; // RULE21
   wire hit_bridge = tpid_ok && in_bridge && bridge_en && (bridge_act != 2'h0); // RULE4
   wire hit_garp = tpid_ok && in_garp && capture_q[ccc_pkg::F_GARP_EN]; // RULE5
   wire hit_cfm = tpid_ok && in_cfm && capture_q[ccc_pkg::F_CFM_EN]; // RULE6
   wire hit_igmp = tpid_ok && in_v4mc && frm_is_ipv4_in && capture_q[ccc_pkg::F_IGMP_EN]
                   && (frm_ip_proto_in == ccc_pkg::PROTO_IGMP); // RULE7
   wire hbh = frm_is_ipv6_in && (frm_ip_proto_in == ccc_pkg::NH_HOPBYHOP);
   wire ra_mld = (frm_hbh_opt_type_in == ccc_pkg::RA_OPT_TYPE)
                 && (frm_hbh_opt_len_in == ccc_pkg::RA_OPT_LEN)
                 && (frm_hbh_opt_data_in == ccc_pkg::RA_OPT_DATA);
   wire is_mld = in_v6mc && hbh && ra_mld;
   wire hit_mld = tpid_ok && is_mld && capture_q[ccc_pkg::F_MLD_EN]; // RULE8
   wire hit_hbh = tpid_ok && hbh && !is_mld && capture_q[ccc_pkg::F_HBH_EN]; // RULE9
   wire icmp = frm_is_ipv6_in && (frm_ip_proto_in == ccc_pkg::NH_ICMPV6);
   wire hit_icmp = tpid_ok && icmp && capture_q[ccc_pkg::F_ICMP_EN]; // RULE10
   wire hit_v4c = tpid_ok && in_v4mc && frm_is_ipv4_in && capture_q[ccc_pkg::F_V4C_EN]
                  && (frm_ip_proto_in != ccc_pkg::PROTO_IGMP)
                  && (frm_ipv4_dip_in[31:8] == ccc_pkg::V4_CTRL_PFX); // RULE11
   wire hit_v6c = tpid_ok && in_v6mc && frm_is_ipv6_in && !hbh && !icmp
                  && capture_q[ccc_pkg::F_V6C_EN]
                  && (frm_ipv6_dip_top_in == ccc_pkg::V6_CTRL_PFX); // RULE12
   // Register-access frame filter.
   wire [11:0] ra_vid = regaccess_vlan_config_q[11:0];
   wire regaccess_vlan_aware_on = regaccess_vlan_config_q[ccc_pkg::F_VAWARE];
   wire ra_vlan_ok = regaccess_vlan_aware_on
                     ? ((frm_tag_count_in == 2'h1) && (frm_outer_vid_in == ra_vid))
                     : (frm_tag_count_in == 2'h0); // RULE16 RULE17
   wire ra_type_ok = (frm_ethertype_in == ccc_pkg::ETYPE_REGACC)
                     && (frm_proto_id_in == ccc_pkg::PROTO_ID_REGACC); // RULE18
   wire ra_hdr_ok = ((frm_regacc_hdr_in ^ regaccess_header_match_value_q)
                     & ~regaccess_header_dont_care_q) == 32'h00000000; // RULE19 RULE22
   wire hit_ra = capture_q[ccc_pkg::F_RA_EN] && ra_vlan_ok && ra_type_ok && ra_hdr_ok; // RULE20
   // Queue numbers: bridge-range queues from their own register.
   wire [2:0] q_bridge = bridge_ctrl_queue_select_q[2:0]; // RULE14
   wire [2:0] q_garp = bridge_ctrl_queue_select_q[5:3]; // RULE14
   wire [2:0] q_cfm = bridge_ctrl_queue_select_q[8:6]; // RULE14
   wire [2:0] q_igmp = protocol_queue_select_q[2:0]; // RULE13
   wire [2:0] q_mld = protocol_queue_select_q[5:3];
   wire [2:0] q_hbh = protocol_queue_select_q[8:6]; // RULE13
   wire [2:0] q_v4c = protocol_queue_select_q[11:9];
   wire [2:0] q_v6c = protocol_queue_select_q[14:12];
   wire [2:0] q_ra = protocol_queue_select_q[17:15];
   wire [1:0] a_garp = group_act_q[1:0];
   wire [1:0] a_cfm = group_act_q[3:2];
   function automatic logic [7:0] qbit(input logic en, input logic [2:0] q);
      qbit = en ? (8'h01 << q) : 8'h00;
   endfunction : qbit
   wire cap_bridge = hit_bridge && (bridge_act != 2'h3);
   wire cap_garp = hit_garp && (a_garp == 2'h1 || a_garp == 2'h2);
   wire cap_cfm = hit_cfm && (a_cfm == 2'h1 || a_cfm == 2'h2);
   wire [7:0] qmask_w = frm_ext_queue_mask_in | qbit(cap_bridge, q_bridge)
                        | qbit(cap_garp, q_garp) | qbit(cap_cfm, q_cfm)
                        | qbit(hit_igmp, q_igmp) | qbit(hit_mld, q_mld)
                        | qbit(hit_hbh | hit_icmp, q_hbh) | qbit(hit_v4c, q_v4c)
                        | qbit(hit_v6c, q_v6c) | qbit(hit_ra, q_ra); // RULE1 RULE13
   wire redir_w = frm_ext_redirect_in || hit_igmp || hit_mld || hit_hbh || hit_icmp || hit_ra
                  || (hit_bridge && bridge_act == 2'h1) || (hit_garp && a_garp == 2'h1)
                  || (hit_cfm && a_cfm == 2'h1);
   wire discard_w = (hit_bridge && bridge_act == 2'h3) || (hit_garp && a_garp == 2'h3)
                    || (hit_cfm && a_cfm == 2'h3);
   wire copy_w = !redir_w && (qmask_w != 8'h00);
   logic res_valid_q;
   logic [7:0] res_queue_mask_q;
   logic res_redirect_q;
   logic res_copy_q;
   logic res_discard_q;
   logic res_keep_q;
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         res_valid_q <= 1'b0;
         res_queue_mask_q <= 8'h00;
         res_redirect_q <= 1'b0;
         res_copy_q <= 1'b0;
         res_discard_q <= 1'b0;
         res_keep_q <= 1'b0;
         frame_count_q <= 16'h0000;
      end else begin
         res_valid_q <= frm_valid_in; // RULE23
         if (frm_valid_in) begin
            res_queue_mask_q <= qmask_w;
            res_redirect_q <= redir_w;
            res_copy_q <= copy_w;
            res_discard_q <= discard_w;
            res_keep_q <= !redir_w && !discard_w; // RULE2 RULE3
            frame_count_q <= frame_count_q + 16'h0001;
         end
      end
   end
   assign res_valid_out = res_valid_q;
   assign res_queue_mask_out = res_queue_mask_q;
   assign res_redirect_out = res_redirect_q;
   assign res_copy_out = res_copy_q;
   assign res_discard_out = res_discard_q;
   assign res_front_ports_keep_out = res_keep_q;
   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_redir_drop;
      @(posedge clk_sys_in) disable iff (srst_in)
      res_valid_out && res_redirect_out |-> !res_front_ports_keep_out;
   endproperty
   a_redir_drop: assert property (p_redir_drop) else $error("redirect kept ports"); // RULE2
   property p_copy_keep;
      @(posedge clk_sys_in) disable iff (srst_in)
      res_valid_out && res_copy_out && !res_discard_out |-> res_front_ports_keep_out;
   endproperty
   a_copy_keep: assert property (p_copy_keep) else $error("copy dropped ports"); // RULE3
   property p_ext_or;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_valid_in |=> ((res_queue_mask_out & $past(frm_ext_queue_mask_in))
                        == $past(frm_ext_queue_mask_in));
   endproperty
   a_ext_or: assert property (p_ext_or) else $error("external queue lost"); // RULE1
   property p_one_result;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_valid_in |=> res_valid_out;
   endproperty
   a_one_result: assert property (p_one_result) else $error("no result"); // RULE23
   property p_double_tag;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_tag_count_in == 2'h2 |-> !ra_vlan_ok;
   endproperty
   a_double_tag: assert property (p_double_tag) else $error("double tag passed"); // RULE17
   property p_icmp_redir;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_valid_in && hit_icmp |=> res_redirect_out && res_queue_mask_out[$past(q_hbh)];
   endproperty
   a_icmp_redir: assert property (p_icmp_redir) else $error("icmpv6 not redirected"); // RULE10
   property p_igmp_redir;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_valid_in && hit_igmp |=> res_redirect_out;
   endproperty
   a_igmp_redir: assert property (p_igmp_redir) else $error("igmp not redirected"); // RULE7
   property p_ra_redir;
      @(posedge clk_sys_in) disable iff (srst_in)
      frm_valid_in && hit_ra |=> res_redirect_out && res_queue_mask_out[$past(q_ra)];
   endproperty
   a_ra_redir: assert property (p_ra_redir) else $error("regaccess not redirected"); // RULE20
endmodule : ccc_classifier

//--- pkg/ccc_pkg.sv
// Package of constants and types for the CPU capture classifier.
package ccc_pkg;
   // ***************************************************************
   // Frame constants
   // ***************************************************************
   localparam logic [47:0] BRIDGE_LO = 48'h0180C2000000;
   localparam logic [47:0] BRIDGE_HI = 48'h0180C200000F;
   localparam logic [47:0] GARP_LO = 48'h0180C2000020;
   localparam logic [47:0] GARP_HI = 48'h0180C200002F;
   localparam logic [47:0] CFM_LO = 48'h0180C2000030;
   localparam logic [47:0] CFM_HI = 48'h0180C200003F;
   localparam logic [47:0] V4MC_LO = 48'h01005E000000;
   localparam logic [47:0] V4MC_HI = 48'h01005E7FFFFF;
   localparam logic [47:0] V6MC_LO = 48'h333300000000;
   localparam logic [47:0] V6MC_HI = 48'h3333FFFFFFFF;
   localparam logic [7:0] PROTO_IGMP = 8'h02;
   localparam logic [7:0] NH_HOPBYHOP = 8'h00;
   localparam logic [7:0] NH_ICMPV6 = 8'h3A;
   localparam logic [7:0] RA_OPT_TYPE = 8'h05;
   localparam logic [7:0] RA_OPT_LEN = 8'h02;
   localparam logic [15:0] RA_OPT_DATA = 16'h0000;
   localparam logic [23:0] V4_CTRL_PFX = 24'hE00000;
   localparam logic [15:0] V6_CTRL_PFX = 16'hFF02;
   localparam logic [15:0] ETYPE_REGACC = 16'h8880;
   localparam logic [15:0] PROTO_ID_REGACC = 16'h0004;
   localparam int NUM_TPID = 5;
   localparam int NUM_BRIDGE = 16;
   // ***************************************************************
   // Register map, byte addresses of 32-bit words
   // ***************************************************************
   localparam logic [7:0] A_CAPTURE = 8'h00;
   localparam logic [7:0] A_BRIDGE_EN = 8'h04;
   localparam logic [7:0] A_BRIDGE_ACT = 8'h08;
   localparam logic [7:0] A_GROUP_ACT = 8'h0C;
   localparam logic [7:0] A_BQUEUE = 8'h10;
   localparam logic [7:0] A_PQUEUE = 8'h14;
   localparam logic [7:0] A_RVLAN = 8'h18;
   localparam logic [7:0] A_RDATA = 8'h1C;
   localparam logic [7:0] A_RMASK = 8'h20;
   localparam logic [7:0] A_STATUS = 8'h24;
   localparam logic [31:0] RESET_ZERO = 32'h00000000;
   localparam logic [31:0] UNMAPPED_DATA = 32'hDEADBEEF;
   // Capture register fields; F_VAWARE is a bit of the register-access VLAN register.
   localparam int F_TPID_LO = 0;
   localparam int F_RA_EN = 8;
   localparam int F_IGMP_EN = 9;
   localparam int F_MLD_EN = 10;
   localparam int F_HBH_EN = 11;
   localparam int F_ICMP_EN = 12;
   localparam int F_V4C_EN = 13;
   localparam int F_V6C_EN = 14;
   localparam int F_GARP_EN = 15;
   localparam int F_CFM_EN = 16;
   localparam int F_VAWARE = 12;
   // Actions of the reserved-address groups.
   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_REDIR = 2'h1,
      ACT_COPY = 2'h2,
      ACT_DISCARD = 2'h3
   } ccc_act_t;
endpackage : ccc_pkg

//--- sim/ccc_classifier_test.sv
// Self-checking testbench of the CPU capture classifier.
`timescale 1ns/1ps
module ccc_classifier_test;
   logic clk_sys_in = 1'h0, srst_in = 1'h1, avs_read_in = 1'h0, avs_write_in = 1'h0;
   logic [7:0] avs_address_in = 8'h00;
   logic [3:0] be = 4'hF;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic avs_waitrequest_out, frm_valid_in, res_valid_out, res_redirect_out, res_copy_out;
   logic res_discard_out, res_front_ports_keep_out, frm_is_ipv4_in, frm_is_ipv6_in;
   logic frm_ext_redirect_in;
   logic [47:0] frm_dmac_in;
   logic [1:0] frm_tag_count_in;
   logic [2:0] frm_outer_tpid_in;
   logic [11:0] frm_outer_vid_in, vid_r;
   logic [15:0] frm_ethertype_in, frm_proto_id_in, frm_ipv6_dip_top_in, frm_hbh_opt_data_in, n_fr;
   logic [31:0] frm_regacc_hdr_in, frm_ipv4_dip_in, hd_r;
   logic [7:0] frm_ip_proto_in, frm_hbh_opt_type_in, frm_hbh_opt_len_in;
   logic [7:0] frm_ext_queue_mask_in, res_queue_mask_out, xm;
   logic [227:0] fields;
   logic [11:0] fq[$];
   logic [31:0] rq[$];
   int mismatches = 0, n_tests = 0, cyc = 0;
   always #4 clk_sys_in = ~clk_sys_in;
   assign {frm_dmac_in, frm_tag_count_in, frm_outer_tpid_in, frm_outer_vid_in, frm_ethertype_in,
      frm_proto_id_in, frm_regacc_hdr_in, frm_is_ipv4_in, frm_is_ipv6_in, frm_ip_proto_in,
      frm_ipv4_dip_in, frm_ipv6_dip_top_in, frm_hbh_opt_type_in, frm_hbh_opt_len_in,
      frm_hbh_opt_data_in, frm_ext_queue_mask_in, frm_ext_redirect_in} = fields;
   ccc_frame_src src (.clk_in(clk_sys_in), .valid_out(frm_valid_in), .fields_out(fields));
   ccc_classifier dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .frm_valid_in(frm_valid_in), .frm_dmac_in(frm_dmac_in), .frm_tag_count_in(frm_tag_count_in),
      .frm_outer_tpid_in(frm_outer_tpid_in), .frm_outer_vid_in(frm_outer_vid_in),
      .frm_ethertype_in(frm_ethertype_in), .frm_proto_id_in(frm_proto_id_in),
      .frm_regacc_hdr_in(frm_regacc_hdr_in), .frm_is_ipv4_in(frm_is_ipv4_in),
      .frm_is_ipv6_in(frm_is_ipv6_in), .frm_ip_proto_in(frm_ip_proto_in),
      .frm_ipv4_dip_in(frm_ipv4_dip_in), .frm_ipv6_dip_top_in(frm_ipv6_dip_top_in),
      .frm_hbh_opt_type_in(frm_hbh_opt_type_in), .frm_hbh_opt_len_in(frm_hbh_opt_len_in),
      .frm_hbh_opt_data_in(frm_hbh_opt_data_in), .frm_ext_queue_mask_in(frm_ext_queue_mask_in),
      .frm_ext_redirect_in(frm_ext_redirect_in), .res_valid_out(res_valid_out),
      .res_queue_mask_out(res_queue_mask_out), .res_redirect_out(res_redirect_out),
      .res_copy_out(res_copy_out), .res_discard_out(res_discard_out),
      .res_front_ports_keep_out(res_front_ports_keep_out));
   // ***************************************************************
   // Checking and closing
   // ***************************************************************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         mismatches++;
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // Expected decision is {queue mask, redirect, copy, discard, keep front ports}.
   always @(posedge clk_sys_in) begin
      cyc++;
      if (res_valid_out === 1'h1) begin
         check("queue mask", res_queue_mask_out, fq[0][11:4]);
         check("decision", {res_redirect_out, res_copy_out, res_discard_out,
            res_front_ports_keep_out}, fq[0][3:0]);
         void'(fq.pop_front());
      end
      if (avs_read_in && avs_waitrequest_out === 1'h0) begin
         check("readdata", avs_readdata_out, rq.pop_front());
      end
      if (cyc == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ***************************************************************
   // Bus master and frame helpers
   // ***************************************************************
   task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= rw;
      avs_write_in <= ~rw;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'h0) @(posedge clk_sys_in);
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'h1, a, 32'h0);
   endtask : rd
   task automatic fr(input logic [11:0] e, input logic [227:0] f);
      fq.push_back(e);
      n_fr++;
      src.send(f);
   endtask : fr
   task automatic mac(input logic [11:0] e, input logic [47:0] d, input logic [8:0] x);
      fr(e, {d, 5'h00, 12'h000, 16'h0000, 16'h0000, 32'h0, 2'h0, 8'h00, 32'h0, 16'h0, 32'h0, x});
   endtask : mac
   task automatic ipf(input logic [11:0] e, input logic [47:0] d, input logic [4:0] tg,
      input logic [1:0] v, input logic [7:0] p, input logic [31:0] a4, input logic [15:0] a6,
      input logic [31:0] h);
      fr(e, {d, tg, 12'h000, 16'h0000, 16'h0000, 32'h0, v, p, a4, a6, h, 9'h000});
   endtask : ipf
   task automatic raf(input logic [11:0] e, input logic [1:0] t, input logic [11:0] v,
      input logic [31:0] h);
      fr(e, {48'h020000000001, t, 3'h1, v, 16'h8880, 16'h0004, h, 42'h0, 16'h0, 32'h0, 9'h000});
   endtask : raf
   initial begin
      n_fr = 16'h0000;
      void'($urandom(32'h3EFD));
      vid_r = 12'($urandom);
      hd_r = $urandom;
      xm = 8'($urandom_range(1, 255));
      repeat (2) @(posedge clk_sys_in);
      srst_in <= 1'h0;
      rd(ccc_pkg::A_BQUEUE, ccc_pkg::RESET_ZERO);
      rd(8'h40, ccc_pkg::UNMAPPED_DATA);
      bus(1'h0, ccc_pkg::A_CAPTURE, 32'h0001FF02);
      bus(1'h0, ccc_pkg::A_BRIDGE_EN, 32'h00000004);
      bus(1'h0, ccc_pkg::A_BRIDGE_ACT, 32'h00000010);
      bus(1'h0, ccc_pkg::A_GROUP_ACT, 32'h0000000E);
      bus(1'h0, ccc_pkg::A_BQUEUE, 32'h000000D1);
      bus(1'h0, ccc_pkg::A_PQUEUE, 32'h00018FAC);
      bus(1'h0, ccc_pkg::A_RVLAN, {19'h0, 1'h1, vid_r});
      bus(1'h0, ccc_pkg::A_RDATA, hd_r);
      bus(1'h0, ccc_pkg::A_RMASK, 32'h0000FFFF);
      rd(ccc_pkg::A_PQUEUE, 32'h00018FAC);
      mac(12'h028, 48'h0180C2000002, 9'h000);
      mac(12'h001, 48'h0180C2000003, 9'h000);
      mac(12'h045, 48'h0180C200002F, 9'h000);
      mac(12'h001, 48'h0180C2000010, 9'h000);
      mac(12'h002, 48'h0180C2000030, 9'h000);
      ipf(12'h108, 48'h01005E7FFFFF, 5'h00, 2'h2, 8'h02, 32'h0A000001, 16'h0, 32'h0);
      ipf(12'h208, 48'h333300000001, 5'h00, 2'h1, 8'h00, 32'h0, 16'hFF02, 32'h05020000);
      ipf(12'h408, 48'h000000000010, 5'h00, 2'h1, 8'h00, 32'h0, 16'h2001, 32'h05020001);
      ipf(12'h408, 48'h333300000003, 5'h00, 2'h1, 8'h3A, 32'h0, 16'hFF02, 32'h0);
      ipf(12'h805, 48'h01005E000001, 5'h00, 2'h2, 8'h11, 32'hE00000FB, 16'h0, 32'h0);
      ipf(12'h015, 48'h333300000002, 5'h00, 2'h1, 8'h11, 32'h0, 16'hFF02, 32'h0);
      ipf(12'h001, 48'h01005E000005, 5'h09, 2'h2, 8'h02, 32'h0, 16'h0, 32'h0);
      ipf(12'h108, 48'h01005E000005, 5'h08, 2'h2, 8'h02, 32'h0, 16'h0, 32'h0);
      raf(12'h088, 2'h1, vid_r, hd_r ^ {16'h0, 16'($urandom)});
      raf(12'h001, 2'h2, vid_r, hd_r);
      raf(12'h001, 2'h1, vid_r ^ 12'h001, hd_r);
      raf(12'h001, 2'h1, vid_r, hd_r ^ 32'h00010000);
      mac({xm, 1'h0, |xm, 2'h1}, 48'h020000000002, {xm, 1'h0});
      mac({xm | 8'h04, 4'h8}, 48'h0180C2000020, {xm, 1'h1});
      src.idle();
      bus(1'h0, ccc_pkg::A_RVLAN, {19'h0, 1'h0, vid_r});
      raf(12'h088, 2'h0, 12'h000, hd_r);
      raf(12'h001, 2'h1, vid_r, hd_r);
      fr(12'h001, {48'h020000000003, 5'h00, 12'h000, 16'h8880, 16'h0005, hd_r, 99'h0});
      src.idle();
      bus(1'h0, ccc_pkg::A_STATUS, 32'hFFFFFFFF);
      // Only byte lane 1 is written, so just the top queue bit of the register changes.
      be <= 4'h2;
      bus(1'h0, ccc_pkg::A_BQUEUE, 32'hFFFFFFFF);
      be <= 4'hF;
      rd(ccc_pkg::A_BQUEUE, 32'h000001D1);
      rd(ccc_pkg::A_STATUS, {16'h0000, n_fr});
      repeat (3) @(posedge clk_sys_in);
      check("pending results", fq.size(), 0);
      end_of_test();
   end
endmodule : ccc_classifier_test

//--- sim/ccc_frame_src.sv
// Model of the ingress parser that hands one parsed frame per clock to the classifier.
`timescale 1ns/1ps
module ccc_frame_src (
   input wire logic clk_in,
   output logic valid_out,
   output logic [227:0] fields_out
);
   initial begin
      valid_out = 1'h0;
      fields_out = '0;
   end
   // Valid stays high until idle is called; consecutive calls give back-to-back frames.
   task automatic send(input logic [227:0] f);
      @(posedge clk_in);
      valid_out <= 1'h1;
      fields_out <= f;
   endtask : send
   // Released fields flip, so a classifier that samples stale fields is caught.
   task automatic idle();
      @(posedge clk_in);
      valid_out <= 1'h0;
      fields_out <= ~fields_out;
   endtask : idle
endmodule : ccc_frame_src
